// [hw/asc_seq.sv]
// Conversion sequencer with status flags and APB register access.
//
// Added by the designer: the APB register port and the placing of the registers.
`default_nettype none
module asc_seq
	import asc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic special_mode,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	output logic conv_start,
	output logic [4:0] conv_source,
	output logic irq
);
	asc_state_t state_r;
	logic [6:0] ctl5_r;
	logic fast_clear_r;
	logic [15:0] test_r;
	logic [2:0] conversion_pointer_r;
	logic sequence_done_flag_r;
	logic first_seq_r;
	logic [7:0] result_done_flags_r;
	logic [7:0] status_seen_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic rd_pend_r;
	logic [7:0] rd_addr_r;
	logic special_q1_r;
	logic special_r;
	logic [2:0] slot;
	logic [2:0] last_slot;
	logic [9:0] mem_rd;
	logic [4:0] source;
	logic setup;
	logic wr;
	logic rd;
	logic start_wr;
	logic conv_end;
	logic seq_end;
	logic res_rd;
	logic [7:0] res_rd_mask;
	logic [7:0] slot_mask;

	function automatic logic is_result(input logic [7:0] a);
		return a[7:5] == ADDR_RESULT0[7:5] && a[1:0] == 2'h0;
	endfunction : is_result

	// Special mode arrives from a pin, so it is synchronised first.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			special_q1_r <= 1'b0;
			special_r <= 1'b0;
		end
		else
		begin
			special_q1_r <= special_mode;
			special_r <= special_q1_r;
		end
	end

	// Reads take one wait state so result data can come from memory.
	assign setup = psel && !penable;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign start_wr = wr && paddr == ADDR_CTL5;
	assign res_rd = rd && is_result(paddr);
	assign slot = paddr[4:2];
	assign res_rd_mask = res_rd ? 8'h01 << slot : 8'h00;
	assign last_slot = ctl5_r[CTL5_S8] ? 3'h7 : 3'h3;
	assign conv_end = state_r == ASC_CONVERT && conv_done;
	assign seq_end = conv_end && conversion_pointer_r == last_slot;
	assign slot_mask = conv_end ? 8'h01 << conversion_pointer_r : 8'h00;

	asc_chan_map u_map (
		.chan_sel(ctl5_r[3:0]),
		.multichannel_enable(ctl5_r[CTL5_MULTICHANNEL_ENABLE]),
		.eight_channel_select(ctl5_r[CTL5_S8]),
		.conv_idx(conversion_pointer_r),
		.source(source)
	);

	asc_result_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(conv_end),
		.wr_slot(conversion_pointer_r),
		.wr_data(conv_data),
		.rd_slot(slot),
		.rd_data(mem_rd)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl5_r <= CTL5_RESET;
			fast_clear_r <= 1'b0;
			irq_mask_r <= IRQ_RESET;
		end
		else if (wr)
		begin
			if (paddr == ADDR_CTL5)
				ctl5_r <= pwdata[6:0];
			if (paddr == ADDR_CTL)
				fast_clear_r <= pwdata[CTL_FAST_CLEAR];
			if (paddr == ADDR_IRQ_MASK)
				irq_mask_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			test_r <= TEST_RESET;
		else if (wr && paddr == ADDR_TEST && special_r)
			test_r <= pwdata[15:0];
	end

	// Sequencer state and pointer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ASC_IDLE;
			conversion_pointer_r <= 3'h0;
			first_seq_r <= 1'b0;
			conv_start <= 1'b0;
			conv_source <= 5'h00;
		end
		else
		begin
			conv_start <= 1'b0;
			if (start_wr)
			begin
				state_r <= ASC_START;
				conversion_pointer_r <= 3'h0;
				first_seq_r <= 1'b1;
			end
			else
			begin
				case (state_r)
					ASC_START:
					begin
						conv_start <= 1'b1;
						conv_source <= source;
						state_r <= ASC_CONVERT;
					end
					ASC_CONVERT:
					begin
						if (conv_done)
						begin
							conversion_pointer_r <= conversion_pointer_r + 3'h1;
							if (seq_end)
							begin
								conversion_pointer_r <= 3'h0;
								first_seq_r <= 1'b0;
								state_r <= ctl5_r[CTL5_SCAN] ? ASC_START : ASC_IDLE;
							end
							else
								state_r <= ASC_START;
						end
					end
					ASC_IDLE:
						state_r <= ASC_IDLE;
					default:
						state_r <= ASC_IDLE;
				endcase
			end
		end
	end

	// Sequence flag: a CTL5 write clears it and wins over set; set wins over the other clears.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sequence_done_flag_r <= 1'b0;
		else if (seq_end && first_seq_r && !start_wr)
			sequence_done_flag_r <= 1'b1;
		else if (start_wr)
			sequence_done_flag_r <= 1'b0;
		else if (wr && paddr == ADDR_STATUS && special_r)
			sequence_done_flag_r <= pwdata[STAT_SEQ_DONE];
		else if (fast_clear_r && res_rd)
			sequence_done_flag_r <= 1'b0;
	end

	// Result flags; a status read arms the normal clear per slot.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_done_flags_r <= 8'h00;
			status_seen_r <= 8'h00;
		end
		else if (start_wr)
		begin
			result_done_flags_r <= 8'h00;
			status_seen_r <= 8'h00;
		end
		else
		begin
			if (wr && paddr == ADDR_STATUS && special_r)
				result_done_flags_r <= pwdata[7:0] | slot_mask;
			else if (fast_clear_r)
				result_done_flags_r <= (result_done_flags_r & ~res_rd_mask)
					| slot_mask;
			else
				result_done_flags_r <= (result_done_flags_r
					& ~(res_rd_mask & status_seen_r)) | slot_mask;
			if (rd && paddr == ADDR_STATUS)
				status_seen_r <= result_done_flags_r & ~slot_mask;
			else
				status_seen_r <= status_seen_r & ~res_rd_mask & ~slot_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_r <= IRQ_RESET;
		else
		begin
			irq_stat_r[IRQ_SEQ_DONE] <= (seq_end && first_seq_r)
				|| (irq_stat_r[IRQ_SEQ_DONE]
				&& !(wr && paddr == ADDR_IRQ_STAT && pwdata[IRQ_SEQ_DONE]));
			irq_stat_r[IRQ_RESULT] <= conv_end
				|| (irq_stat_r[IRQ_RESULT]
				&& !(wr && paddr == ADDR_IRQ_STAT && pwdata[IRQ_RESULT]));
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_r & irq_mask_r);
	end

	// APB answer: writes complete in the access cycle, reads one later.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= 8'h00;
		end
		else
		begin
			rd_pend_r <= setup && !pwrite;
			rd_addr_r <= paddr;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= (setup && pwrite) || rd_pend_r;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (rd_pend_r)
			begin
				case (rd_addr_r)
					ADDR_CTL5: prdata <= {25'h0, ctl5_r};
					ADDR_CTL: prdata <= {31'h0, fast_clear_r};
					ADDR_STATUS: prdata <= {16'h0, sequence_done_flag_r,
						4'h0, conversion_pointer_r, result_done_flags_r};
					ADDR_TEST: prdata <= special_r ? {16'h0, test_r} : 32'h0;
					ADDR_IRQ_STAT: prdata <= {30'h0, irq_stat_r};
					ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask_r};
					default:
					begin
						if (is_result(rd_addr_r))
							prdata <= {22'h0, mem_rd};
						else
							pslverr <= 1'b1;
					end
				endcase
			end
			else if (setup && pwrite && !(paddr == ADDR_CTL5
				|| paddr == ADDR_CTL || paddr == ADDR_STATUS
				|| paddr == ADDR_TEST || paddr == ADDR_IRQ_STAT
				|| paddr == ADDR_IRQ_MASK))
				pslverr <= 1'b1;
		end
	end
endmodule : asc_seq
`default_nettype wire

// [pkg/asc_pkg.sv]
// Package with register map, field positions and types of the sequencer.
`default_nettype none
package asc_pkg;
	localparam logic [7:0] ADDR_CTL5 = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TEST = 8'h08;
	localparam logic [7:0] ADDR_CTL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_RESULT0 = 8'h20;
	localparam int CTL5_CHAN_LSB = 0;
	localparam int CTL5_MULTICHANNEL_ENABLE = 4;
	localparam int CTL5_SCAN = 5;
	localparam int CTL5_S8 = 6;
	localparam int CTL_FAST_CLEAR = 0;
	localparam int STAT_PTR_LSB = 8;
	localparam int STAT_SEQ_DONE = 15;
	localparam int IRQ_SEQ_DONE = 0;
	localparam int IRQ_RESULT = 1;
	localparam logic [6:0] CTL5_RESET = 7'h00;
	localparam logic [15:0] TEST_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [4:0] SRC_RESERVED = 5'h10;
	localparam logic [4:0] SRC_VRH = 5'h11;
	localparam logic [4:0] SRC_VRL = 5'h12;
	localparam logic [4:0] SRC_MID = 5'h13;
	localparam logic [4:0] SRC_TEST = 5'h14;
	typedef enum logic [1:0] {
		ASC_IDLE,
		ASC_START,
		ASC_CONVERT
	} asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// [hw/asc_result_mem.sv]
// Eight-slot result memory with registered read data.
`default_nettype none
module asc_result_mem
	import asc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [2:0] wr_slot,
	input wire logic [9:0] wr_data,
	input wire logic [2:0] rd_slot,
	output logic [9:0] rd_data
);
	logic [9:0] mem [8];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 8; i++)
				mem[i] <= RESULT_RESET;
		end
		else if (wr_en)
			mem[wr_slot] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= RESULT_RESET;
		else
			rd_data <= mem[rd_slot];
	end
endmodule : asc_result_mem
`default_nettype wire

// [hw/asc_chan_map.sv]
// Maps select code, options and conversion index onto an input source.
`default_nettype none
module asc_chan_map
	import asc_pkg::*;
(
	input wire logic [3:0] chan_sel,
	input wire logic multichannel_enable,
	input wire logic eight_channel_select,
	input wire logic [2:0] conv_idx,
	output logic [4:0] source
);
	logic [3:0] code;

	always_comb
	begin
		code = chan_sel;
		if (multichannel_enable)
		begin
			if (eight_channel_select)
				code = {chan_sel[3], conv_idx};
			else
				code = {chan_sel[3:2], conv_idx[1:0]};
		end
		// Single channel keeps the full code for every conversion.
		if (!code[3])
			source = {2'h0, code[2:0]};
		else
		begin
			case (code[2:0])
				3'h4: source = SRC_VRH;
				3'h5: source = SRC_VRL;
				3'h6: source = SRC_MID;
				3'h7: source = SRC_TEST;
				default: source = SRC_RESERVED;
			endcase
		end
	end
endmodule : asc_chan_map
`default_nettype wire

// [dv/asc_seq_chk.sv]
// Port checker of the sequencer: bus timing and start pulses.
`default_nettype none
module asc_seq_chk
	import asc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic special_mode,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	input wire logic conv_start,
	input wire logic [4:0] conv_source,
	input wire logic irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable && !$past(penable);
	endsequence
	sequence s_ctl5;
		psel && penable && pwrite && pready && paddr == ADDR_CTL5;
	endsequence
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held high");
	a_write_nowait: assert property (s_acc ##0 pwrite |-> pready)
		else $error("write waited");
	a_read_wait: assert property (s_acc ##0 !pwrite |-> !pready ##1 pready)
		else $error("read wait wrong");
	a_start_follow: assert property (s_ctl5 |-> ##[1:3] conv_start)
		else $error("no start after write");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start held high");
	// Mode changes lag by the synchroniser, so look back four cycles.
	a_test_zero: assert property (psel && !pwrite && pready &&
		paddr == ADDR_TEST && !special_mode && !$past(special_mode, 4)
		|-> prdata == 32'h0)
		else $error("test register leaked");
	a_unmapped_err: assert property (psel && penable && pready &&
		paddr == 8'h18 |-> pslverr)
		else $error("unmapped without error");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule : asc_seq_chk
bind asc_seq asc_seq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .special_mode, .conv_done,
	.conv_data, .conv_start, .conv_source, .irq);
`default_nettype wire

// [dv/asc_seq_tb_top.sv]
// Register-level bench of the sequencer.
`default_nettype none
module asc_seq_tb_top
	import asc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic special_mode = 1'h0;
	logic conv_done = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [9:0] conv_data = 10'h0;
	logic [31:0] prdata;
	logic [31:0] r;
	logic [4:0] conv_source;
	logic pready;
	logic pslverr;
	logic conv_start;
	logic irq;
	logic e;
	logic [6:0] mv[6] = '{7'h1c, 7'h18, 7'h50, 7'h58, 7'h43, 7'h05};
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	// Start pulses are counted, so a bus access may overlap one of them.
	int start_cnt = 0;
	asc_seq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .special_mode, .conv_done,
		.conv_data, .conv_start, .conv_source, .irq);
	always #4 pclk = ~pclk;
	task summarize();
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	always @(posedge pclk)
	begin
		cyc++;
		if (conv_start === 1'h1)
			start_cnt++;
		if (cyc == 20000)
		begin
			fail_count++;
			summarize();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (w && a == ADDR_CTL5)
			start_cnt = 0;
	endtask : apb
	task st(input logic [31:0] x);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(r & 32'h80ff, x);
	endtask : st
	function automatic logic [4:0] src(input logic [6:0] c, input int k);
		logic [3:0] n;
		n = c[6] ? {c[3], 3'(k)} : {c[3:2], 2'(k)};
		if (!c[4])
			n = c[3:0];
		if (!n[3])
			return {2'h0, n[2:0]};
		return n[2] ? SRC_VRH + 5'(n[1:0]) : SRC_RESERVED;
	endfunction : src
	task conv(input logic [4:0] s, input logic [9:0] d);
		while (start_cnt == 0)
			@(posedge pclk);
		start_cnt--;
		chk(32'(conv_source), 32'(s));
		conv_done <= 1'h1;
		conv_data <= d;
		@(posedge pclk);
		conv_done <= 1'h0;
	endtask : conv
	task seq(input logic [6:0] c, input logic [9:0] b);
		apb(1'h1, ADDR_CTL5, 32'(c));
		for (int k = 0; k < (c[6] ? 8 : 4); k++)
			conv(src(c, k), b + 10'(k));
	endtask : seq
	task res(input int n, input logic [9:0] b);
		for (int k = 0; k < n; k++)
		begin
			apb(1'h0, ADDR_RESULT0 + 8'(4 * k), 32'h0);
			chk(r, 32'(b + 10'(k)));
		end
	endtask : res
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		st(32'h0);
		apb(1'h1, ADDR_TEST, 32'h5a);
		apb(1'h0, ADDR_TEST, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		chk(32'(e), 32'h1);
		$display("t1 done");
		seq(7'h14, 10'h2a0);
		apb(1'h0, ADDR_RESULT0, 32'h0);
		st(32'h800f);
		apb(1'h0, ADDR_RESULT0, 32'h0);
		st(32'h800e);
		apb(1'h1, ADDR_CTL5, 32'h14);
		st(32'h0);
		$display("t2 done");
		foreach (mv[i])
		begin
			seq(mv[i], 10'(i * 16));
			res(mv[i][6] ? 8 : 4, 10'(i * 16));
		end
		$display("t3 done");
		apb(1'h1, ADDR_IRQ_MASK, 32'h0);
		apb(1'h1, ADDR_CTL, 32'h1);
		seq(7'h58, 10'h100);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'h1, ADDR_IRQ_MASK, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h1);
		apb(1'h0, ADDR_RESULT0 + 8'h14, 32'h0);
		st(32'h00df);
		apb(1'h1, ADDR_IRQ_STAT, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		$display("t4 done");
		apb(1'h1, ADDR_CTL5, 32'h30);
		conv(5'h0, 10'h200);
		conv(5'h1, 10'h201);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(r, 32'h0203);
		conv(5'h2, 10'h202);
		conv(5'h3, 10'h203);
		apb(1'h0, ADDR_RESULT0, 32'h0);
		for (int k = 0; k < 4; k++)
			conv(src(7'h30, k), 10'h210 + 10'(k));
		st(32'h000f);
		apb(1'h0, ADDR_RESULT0, 32'h0);
		chk(r, 32'h210);
		apb(1'h1, ADDR_CTL5, 32'h0);
		apb(1'h1, ADDR_STATUS, 32'h80ff);
		st(32'h0);
		$display("t5 done");
		special_mode <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h1, ADDR_TEST, 32'ha5);
		apb(1'h0, ADDR_TEST, 32'h0);
		chk(r, 32'ha5);
		apb(1'h1, ADDR_STATUS, 32'h8001);
		st(32'h8001);
		special_mode <= 1'h0;
		$display("t6 done");
		summarize();
	end
endmodule : asc_seq_tb_top
`default_nettype wire
